/* File: csp_pkg.sv */
// Constants and types shared by the serial port block.
package csp_pkg;

  // ***************************************************************
  // Clock and timing
  // ***************************************************************
  localparam int CLK_HZ       = 100_000_000;
  localparam int RTS_UNIT_MS  = 20;
  localparam int RTS_UNIT_CYC = CLK_HZ / 1000 * RTS_UNIT_MS;
  localparam int BAUD_COUNT   = 8;
  localparam int BAUD_RATE [BAUD_COUNT] =
    '{110, 300, 600, 1200, 2400, 4800, 9600, 19200};
  localparam logic [2:0] BAUD_DEFAULT = 3'h7;
  localparam int DIV_W   = 20;
  localparam int FRAME_W = 12;
  localparam int DUNIT_W = 32;

  // ***************************************************************
  // Register map, byte addresses
  // ***************************************************************
  localparam int ADDR_W = 5;
  localparam logic [ADDR_W-1:0] OFS_CTRL   = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_DELAY  = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_TXDATA = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_RXDATA = 5'h0C;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 5'h10;

  // Status bit positions.
  localparam int ST_TX_READY  = 0;
  localparam int ST_TX_IDLE   = 1;
  localparam int ST_RTS       = 2;
  localparam int ST_RX_VALID  = 3;
  localparam int ST_OVERRUN   = 4;
  localparam int ST_PARITY    = 5;
  localparam int ST_FRAMING   = 6;

  // ***************************************************************
  // Configuration types
  // ***************************************************************
  typedef enum logic [1:0] {PAR_NONE, PAR_EVEN, PAR_ODD, PAR_RSVD}
    csp_parity_t;
  typedef enum logic {MODE_USER, MODE_SYSTEM} csp_mode_t;
  typedef enum logic [1:0] {PROTO_P2P, PROTO_SLAVE, PROTO_MASTER,
    PROTO_RSVD} csp_proto_t;
  typedef enum logic [1:0] {HS_NONE, HS_FULL, HS_HALF, HS_RSVD}
    csp_hs_t;

  typedef struct packed {
    logic        contCarrier;
    csp_hs_t     handshake;
    csp_proto_t  protocol;
    csp_mode_t   mode;
    logic        stop2;
    csp_parity_t parity;
    logic        data7;
    logic [2:0]  baud;
  } csp_cfg_t;
  localparam int CFG_W = $bits(csp_cfg_t);
  localparam csp_cfg_t CFG_RESET = '{contCarrier: 1'b0,
    handshake: HS_NONE, protocol: PROTO_P2P, mode: MODE_USER,
    stop2: 1'b0, parity: PAR_NONE, data7: 1'b0, baud: BAUD_DEFAULT};

  typedef struct packed {
    logic [7:0] offDelay;
    logic [7:0] sendDelay;
  } csp_delay_t;
  localparam csp_delay_t DELAY_RESET = '{offDelay: 8'h00,
    sendDelay: 8'h00};

  typedef struct packed {
    logic       frameErr;
    logic       parityErr;
    logic [7:0] data;
  } csp_rxword_t;
  localparam csp_rxword_t RXWORD_RESET = '{1'b0, 1'b0, 8'h00};

endpackage

/* File: csp_buf2.sv */
// Two-entry valid/ready buffer placed in the transmit data path.
`timescale 1ns/1ps

module csp_buf2
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
)
(
  // Clock and reset.
  input  wire logic             clk_sys,
  input  wire logic             sys_rst,
  // Filling side.
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  // Draining side.
  output logic                  outValid,
  input  wire logic             outReady,
  output logic [WIDTH-1:0]      outData
);

  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] memReg [DEPTH];
  logic [PTR_W-1:0] wrPtrReg;
  logic [PTR_W-1:0] rdPtrReg;
  logic [PTR_W:0]   countReg;
  logic             push;
  logic             pop;

  // Full and empty follow the entry count, so neither side is misled.
  assign inReady  = countReg != (PTR_W+1)'(DEPTH);
  assign outValid = countReg != '0;
  assign outData  = memReg[rdPtrReg];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  // Storage needs no reset; the count guards every read.
  always_ff @(posedge clk_sys)
  begin
    if (push)
      memReg[wrPtrReg] <= inData;
  end

  // Pointers wrap at the depth, which need not be a power of two.
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      wrPtrReg <= '0;
      rdPtrReg <= '0;
      countReg <= '0;
    end
    else
    begin
      if (push)
        wrPtrReg <= (wrPtrReg == PTR_W'(DEPTH-1)) ? '0 : wrPtrReg + 1'b1;
      if (pop)
        rdPtrReg <= (rdPtrReg == PTR_W'(DEPTH-1)) ? '0 : rdPtrReg + 1'b1;
      if (push && !pop)
        countReg <= countReg + 1'b1;
      else if (pop && !push)
        countReg <= countReg - 1'b1;
    end
  end

endmodule

/* File: csp_uart.sv */
// Serial port core: register slave, RTS-sequenced transmitter, receiver.
`timescale 1ns/1ps
//
// Summary of operation
// - Eight selectable baud rates, 19200 after reset.
// - Eight data bits; seven only in user mode.
// - Parity none, even or odd; odd user only.
// - One stop bit; two only in user mode.
// - System or user mode, user after reset.
// - Handshake limited by mode and protocol, none default.
// - Continuous carrier only half duplex, never master in system mode.
// - Send delay after RTS before first character.
// - Off delay after last character, then drop RTS.

module csp_uart
  import csp_pkg::*;
#(
  parameter int CLK_FREQ_HZ  = CLK_HZ,
  parameter int DLY_UNIT_CYC = RTS_UNIT_CYC
)
(
  // Clock and reset.
  input  wire logic              clk_sys,
  input  wire logic              sys_rst,
  // Avalon-MM register slave.
  input  wire logic [ADDR_W-1:0] avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  output logic      [31:0]       avs_readdata,
  output logic                   avs_waitrequest,
  // Serial line.
  input  wire logic              serRxd,
  output logic                   serTxd,
  output logic                   serRts
);

  typedef enum logic [1:0] {TX_IDLE, TX_LEAD, TX_SHIFT, TX_TAIL}
    csp_tx_state_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} csp_rx_state_t;

  csp_cfg_t         cfgReg;
  csp_cfg_t         eff;
  csp_delay_t       dlyReg;
  logic [DIV_W-1:0] divTab [BAUD_COUNT];
  logic [DIV_W-1:0] bitDiv;
  logic             waitReg;
  logic [31:0]      rdataReg;
  logic [31:0]      readMux;
  logic             req;
  logic             canTake;
  logic             taken;
  logic             bufInReady;
  logic             bufOutValid;
  logic [7:0]       bufOutData;
  logic             pushTx;
  csp_tx_state_t    txState;
  logic [FRAME_W-1:0] txShiftReg;
  logic [DIV_W-1:0] txDivCnt;
  logic [3:0]       txBitsLeft;
  logic             txdReg;
  logic             rtsReg;
  logic             txTick;
  logic             txLast;
  logic             txLoad;
  logic [DUNIT_W-1:0] dlyUnitCnt;
  logic [7:0]       dlyUnits;
  logic [7:0]       dlyTarget;
  logic             dlyDone;
  logic             rxSync1;
  logic             rxIn;
  logic             rxPrev;
  csp_rx_state_t    rxState;
  logic [DIV_W-1:0] rxDivCnt;
  logic [3:0]       rxBitIdx;
  logic [10:0]      rxShiftReg;
  logic [10:0]      rxFull;
  logic [3:0]       rxNumData;
  logic [3:0]       rxNeed;
  logic             rxEnd;
  csp_rxword_t      rxWord;
  csp_rxword_t      rxHoldReg;
  logic             rxValidReg;
  logic             rxOverrunReg;
  logic             rdRxData;

  // ***************************************************************
  // Configuration legalisation
  // ***************************************************************

  // Illegal combinations are forced to a safe value, and CTRL reads
  // back the setting in force so software can see what was refused.
  always_comb
  begin
    eff = cfgReg;
    if (eff.mode == MODE_SYSTEM)
    begin
      eff.data7 = 1'b0;
      eff.stop2 = 1'b0;
      if (eff.parity == PAR_ODD)
        eff.parity = PAR_NONE;
      if (eff.protocol == PROTO_P2P && eff.handshake == HS_HALF)
        eff.handshake = HS_NONE;
      if (eff.protocol == PROTO_SLAVE && eff.handshake == HS_FULL)
        eff.handshake = HS_NONE;
    end
    if (eff.parity == PAR_RSVD)
      eff.parity = PAR_NONE;
    if (eff.handshake == HS_RSVD)
      eff.handshake = HS_NONE;
    eff.contCarrier = cfgReg.contCarrier && eff.handshake == HS_HALF
      && !(eff.mode == MODE_SYSTEM && eff.protocol == PROTO_MASTER);
  end

  // One divisor per selectable rate, all fixed at elaboration.
  for (genvar i = 0; i < BAUD_COUNT; i++)
  begin : g_div
    assign divTab[i] = DIV_W'(CLK_FREQ_HZ / BAUD_RATE[i]);
  end
  assign bitDiv = divTab[eff.baud];

  // ***************************************************************
  // Avalon-MM slave
  // ***************************************************************

  // A TXDATA write is held off while the buffer is full.
  assign req      = avs_read || avs_write;
  assign canTake  = !(avs_write && avs_address == OFS_TXDATA && !bufInReady);
  assign taken    = req && !waitReg;
  assign pushTx   = taken && avs_write && avs_address == OFS_TXDATA;
  assign rdRxData = taken && avs_read && avs_address == OFS_RXDATA;

  // Read data for the addressed register; unmapped words read zero.
  always_comb
  begin
    readMux = 32'h0000_0000;
    if (avs_address == OFS_CTRL)
      readMux[CFG_W-1:0] = eff;
    else if (avs_address == OFS_DELAY)
      readMux[15:0] = dlyReg;
    else if (avs_address == OFS_RXDATA)
      readMux[7:0] = rxHoldReg.data;
    else if (avs_address == OFS_STATUS)
    begin
      readMux[ST_TX_READY] = bufInReady;
      readMux[ST_TX_IDLE]  = txState == TX_IDLE && !bufOutValid;
      readMux[ST_RTS]      = rtsReg;
      readMux[ST_RX_VALID] = rxValidReg;
      readMux[ST_OVERRUN]  = rxOverrunReg;
      readMux[ST_PARITY]   = rxHoldReg.parityErr;
      readMux[ST_FRAMING]  = rxHoldReg.frameErr;
    end
  end

  // Waitrequest drops for exactly one cycle, one edge after the
  // request can be served; read data is latched on that same edge.
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      waitReg  <= 1'b1;
      rdataReg <= 32'h0000_0000;
    end
    else
    begin
      waitReg <= !(req && waitReg && canTake);
      if (avs_read && waitReg)
        rdataReg <= readMux;
    end
  end

  // Configuration registers written by software.
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cfgReg <= CFG_RESET;
      dlyReg <= DELAY_RESET;
    end
    else if (taken && avs_write)
    begin
      if (avs_address == OFS_CTRL)
        cfgReg <= csp_cfg_t'(avs_writedata[CFG_W-1:0]);
      else if (avs_address == OFS_DELAY)
        dlyReg <= csp_delay_t'(avs_writedata[15:0]);
    end
  end

  // ***************************************************************
  // Transmit path
  // ***************************************************************

  csp_buf2 #(.WIDTH(8), .DEPTH(2)) u_txbuf (
    .clk_sys  (clk_sys),
    .sys_rst  (sys_rst),
    .inValid  (pushTx),
    .inReady  (bufInReady),
    .inData   (avs_writedata[7:0]),
    .outValid (bufOutValid),
    .outReady (txLoad),
    .outData  (bufOutData)
  );

  // Frame: start, data LSB first, optional parity, stop ones.
  function automatic logic [FRAME_W-1:0] buildFrame(
    input logic [7:0] d,
    input csp_cfg_t   c
  );
    logic [FRAME_W-1:0] f;
    logic               p;
    int                 n;
    f = {FRAME_W{1'b1}};
    n = c.data7 ? 7 : 8;
    p = ^(c.data7 ? {1'b0, d[6:0]} : d);
    if (c.parity == PAR_ODD)
      p = !p;
    f[0] = 1'b0;
    for (int i = 0; i < 8; i++)
      if (i < n)
        f[i+1] = d[i];
    if (c.parity != PAR_NONE)
      f[n+1] = p;
    return f;
  endfunction

  assign txTick = txDivCnt == '0;
  assign txLast = txState == TX_SHIFT && txTick && txBitsLeft == 4'h0;

  // The delay counts whole units while waiting; leaving either wait
  // state clears it, so each wait starts from zero.
  assign dlyTarget = (txState == TX_LEAD) ? dlyReg.sendDelay
                                          : dlyReg.offDelay;
  assign dlyDone   = dlyUnits == dlyTarget - 8'h01
                     && dlyUnitCnt == DUNIT_W'(DLY_UNIT_CYC - 1);

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      dlyUnitCnt <= '0;
      dlyUnits   <= 8'h00;
    end
    else if (txState == TX_LEAD || txState == TX_TAIL)
    begin
      if (dlyUnitCnt == DUNIT_W'(DLY_UNIT_CYC - 1))
      begin
        dlyUnitCnt <= '0;
        dlyUnits   <= dlyUnits + 8'h01;
      end
      else
        dlyUnitCnt <= dlyUnitCnt + 1'b1;
    end
    else
    begin
      dlyUnitCnt <= '0;
      dlyUnits   <= 8'h00;
    end
  end

  // A character starts when one is waiting and the line may be used.
  // Characters queued back to back form one message under one RTS.
  always_comb
  begin
    txLoad = 1'b0;
    if (bufOutValid)
    begin
      case (txState)
        TX_IDLE:  txLoad = eff.handshake == HS_NONE || rtsReg
                           || dlyReg.sendDelay == 8'h00;
        TX_LEAD:  txLoad = dlyDone;
        TX_SHIFT: txLoad = txLast;
        TX_TAIL:  txLoad = 1'b1;
        default:  txLoad = 1'b0;
      endcase
    end
  end

  // Transmitter sequencing and the two line outputs.
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      txState    <= TX_IDLE;
      txShiftReg <= {FRAME_W{1'b1}};
      txDivCnt   <= '0;
      txBitsLeft <= 4'h0;
      txdReg     <= 1'b1;
      rtsReg     <= 1'b0;
    end
    else if (txLoad)
    begin
      txShiftReg <= buildFrame(bufOutData, eff) >> 1;
      txdReg     <= 1'b0;
      txBitsLeft <= 4'(1 + (eff.data7 ? 7 : 8)
                    + (eff.parity != PAR_NONE ? 1 : 0)
                    + (eff.stop2 ? 2 : 1) - 1);
      txDivCnt   <= bitDiv - 1'b1;
      txState    <= TX_SHIFT;
      rtsReg     <= eff.handshake != HS_NONE;
    end
    else
    begin
      case (txState)
        TX_IDLE:
        begin
          rtsReg <= eff.contCarrier;
          if (bufOutValid)
          begin
            rtsReg  <= 1'b1;
            txState <= TX_LEAD;
          end
        end
        TX_LEAD:
          rtsReg <= 1'b1;
        TX_SHIFT:
        begin
          txDivCnt <= txTick ? bitDiv - 1'b1 : txDivCnt - 1'b1;
          if (txLast)
          begin
            if (eff.handshake == HS_NONE || dlyReg.offDelay == 8'h00)
            begin
              rtsReg  <= eff.contCarrier;
              txState <= TX_IDLE;
            end
            else
              txState <= TX_TAIL;
          end
          else if (txTick)
          begin
            txdReg     <= txShiftReg[0];
            txShiftReg <= {1'b1, txShiftReg[FRAME_W-1:1]};
            txBitsLeft <= txBitsLeft - 4'h1;
          end
        end
        TX_TAIL:
          if (dlyDone)
          begin
            rtsReg  <= eff.contCarrier;
            txState <= TX_IDLE;
          end
        default:
          txState <= TX_IDLE;
      endcase
    end
  end

  assign serTxd = txdReg;
  assign serRts = rtsReg;

  // ***************************************************************
  // Receive path
  // ***************************************************************

  // The line is asynchronous: two flops before any logic reads it.
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rxSync1 <= 1'b1;
      rxIn    <= 1'b1;
      rxPrev  <= 1'b1;
    end
    else
    begin
      rxSync1 <= serRxd;
      rxIn    <= rxSync1;
      rxPrev  <= rxIn;
    end
  end

  // Assemble the sampled bits and check parity and the first stop.
  always_comb
  begin
    rxFull           = rxShiftReg;
    rxFull[rxBitIdx] = rxIn;
    rxNumData = eff.data7 ? 4'h7 : 4'h8;
    rxNeed    = rxNumData + ((eff.parity != PAR_NONE) ? 4'h1 : 4'h0);
    rxEnd     = rxState == RX_BITS && rxDivCnt == '0 && rxBitIdx == rxNeed;
    rxWord.data = eff.data7 ? {1'b0, rxFull[6:0]} : rxFull[7:0];
    rxWord.parityErr = eff.parity != PAR_NONE
      && ((^rxWord.data ^ rxFull[rxNumData]) != (eff.parity == PAR_ODD));
    rxWord.frameErr = !rxFull[rxNeed];
  end

  // Sampling runs mid-bit: half a bit after the falling start edge.
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rxState    <= RX_IDLE;
      rxDivCnt   <= '0;
      rxBitIdx   <= 4'h0;
      rxShiftReg <= 11'h7FF;
    end
    else
    begin
      case (rxState)
        RX_IDLE:
          if (rxPrev && !rxIn)
          begin
            rxDivCnt <= (bitDiv >> 1) - 1'b1;
            rxState  <= RX_START;
          end
        RX_START:
          if (rxDivCnt != '0)
            rxDivCnt <= rxDivCnt - 1'b1;
          else if (rxIn)
            rxState <= RX_IDLE;
          else
          begin
            rxDivCnt <= bitDiv - 1'b1;
            rxBitIdx <= 4'h0;
            rxState  <= RX_BITS;
          end
        RX_BITS:
          if (rxDivCnt != '0)
            rxDivCnt <= rxDivCnt - 1'b1;
          else
          begin
            rxShiftReg <= rxFull;
            rxBitIdx   <= rxBitIdx + 4'h1;
            rxDivCnt   <= bitDiv - 1'b1;
            if (rxEnd)
              rxState <= RX_IDLE;
          end
        default:
          rxState <= RX_IDLE;
      endcase
    end
  end

  // Holding register. A word arriving on the edge of a read wins, and
  // overrun is cleared by writing one to its status bit.
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rxHoldReg    <= RXWORD_RESET;
      rxValidReg   <= 1'b0;
      rxOverrunReg <= 1'b0;
    end
    else
    begin
      if (rxEnd)
        rxHoldReg <= rxWord;
      if (rxEnd)
        rxValidReg <= 1'b1;
      else if (rdRxData)
        rxValidReg <= 1'b0;
      if (rxEnd && rxValidReg && !rdRxData)
        rxOverrunReg <= 1'b1;
      else if (taken && avs_write && avs_address == OFS_STATUS
               && avs_writedata[ST_OVERRUN])
        rxOverrunReg <= 1'b0;
    end
  end

  assign avs_readdata    = rdataReg;
  assign avs_waitrequest = waitReg;

  // ***************************************************************
  // Assertions
  // ***************************************************************

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  sequence s_last_bit;
    txLast && !bufOutValid;
  endsequence

  sequence s_lead_start;
    txState == TX_IDLE && !txLoad && bufOutValid;
  endsequence

  a_baud_default: assert property ($fell(sys_rst) |->
    cfgReg.baud == BAUD_DEFAULT && bitDiv == divTab[7])
    else $error("baud not at default after reset");
  a_system_eight: assert property (eff.mode == MODE_SYSTEM |->
    !eff.data7)
    else $error("seven data bits in system mode");
  a_odd_user: assert property (eff.parity == PAR_ODD |->
    eff.mode == MODE_USER)
    else $error("odd parity outside user mode");
  a_stop_user: assert property (eff.stop2 |->
    eff.mode == MODE_USER)
    else $error("two stop bits outside user mode");
  a_mode_default: assert property ($fell(sys_rst) |->
    cfgReg.mode == MODE_USER && cfgReg.handshake == HS_NONE)
    else $error("mode or handshake not at default");
  a_hs_allowed: assert property (eff.mode == MODE_SYSTEM |->
    !(eff.protocol == PROTO_P2P && eff.handshake == HS_HALF)
    && !(eff.protocol == PROTO_SLAVE && eff.handshake == HS_FULL))
    else $error("handshake illegal for protocol");
  a_carrier_gate: assert property (eff.contCarrier |->
    eff.handshake == HS_HALF && !(eff.mode == MODE_SYSTEM
    && eff.protocol == PROTO_MASTER))
    else $error("continuous carrier where not allowed");
  a_lead_quiet: assert property (s_lead_start |=>
    txState == TX_LEAD && rtsReg && txdReg)
    else $error("send delay not honoured");
  a_off_hold: assert property (s_last_bit ##0
    (eff.handshake != HS_NONE && dlyReg.offDelay != 8'h00)
    |=> txState == TX_TAIL && rtsReg)
    else $error("RTS dropped before off delay");
  a_start_low: assert property (txLoad |=> !txdReg ##1
    !txdReg || txState == TX_SHIFT)
    else $error("start bit not driven low");
  a_idle_high: assert property (txState == TX_IDLE |-> txdReg)
    else $error("line not idle high");
  a_no_rts: assert property ((eff.handshake == HS_NONE) [*2] |->
    !rtsReg && txState != TX_LEAD)
    else $error("RTS sequencing without handshake");
  a_one_answer: assert property (taken |=> avs_waitrequest)
    else $error("waitrequest low for two cycles");

endmodule

/* File: csp_remote.sv */
// Remote serial station model that receives and sends frames.
`timescale 1ns/1ps
module csp_remote
(
  // Clock.
  input  wire logic clk_sys,
  // Serial line from and to the port.
  input  wire logic serTxd,
  output logic      serRxd
);
  // Bit time in cycles; the bench may change it.
  int         bitCyc = 100;
  int         nGot   = 0;
  logic [7:0] got;
  initial serRxd = 1'b1;
  // Sample mid-bit, LSB first; count a frame only if its stop is high.
  always
  begin
    @(negedge serTxd);
    repeat (bitCyc / 2) @(posedge clk_sys);
    for (int i = 0; i < 9; i++)
    begin
      repeat (bitCyc) @(posedge clk_sys);
      if (i < 8) got[i] = serTxd;
      else if (serTxd) nGot++;
    end
  end
  // Send one frame, eight bits, no parity, one stop; line left high.
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      @(posedge clk_sys);
      serRxd <= f[i];
      repeat (bitCyc - 1) @(posedge clk_sys);
    end
  endtask
endmodule

/* File: tb_controller_serial_port_uart.sv */
// Self-checking bench for the serial port core.
`timescale 1ns/1ps
module tb_controller_serial_port_uart;
  import csp_pkg::*;
  logic              clk_sys = 1'b0;
  logic              sys_rst = 1'b1;
  logic [ADDR_W-1:0] avs_address = '0;
  logic              avs_read = 1'b0;
  logic              avs_write = 1'b0;
  logic [31:0]       avs_writedata = '0;
  logic [31:0]       avs_readdata;
  logic              avs_waitrequest;
  logic              serRxd;
  logic              serTxd;
  logic              serRts;
  logic [31:0]       q;
  int                fails = 0;
  int                tests_run = 0;
  int                rtsCyc = 0;
  int                n0;
  // Clock shortened so that one bit at 19200 lasts 100 cycles.
  csp_uart #(.CLK_FREQ_HZ(1920000), .DLY_UNIT_CYC(4)) DUT (
    .clk_sys         (clk_sys),
    .sys_rst         (sys_rst),
    .avs_address     (avs_address),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_writedata   (avs_writedata),
    .avs_readdata    (avs_readdata),
    .avs_waitrequest (avs_waitrequest),
    .serRxd          (serRxd),
    .serTxd          (serTxd),
    .serRts          (serRts)
  );
  csp_remote R (.clk_sys(clk_sys), .serTxd(serTxd), .serRxd(serRxd));
  initial forever #5 clk_sys = ~clk_sys;
  // Length of each request-to-send assertion, in cycles.
  always @(posedge clk_sys) if (serRts === 1'b1) rtsCyc++;
  // One bus access; held until waitrequest is sampled low.
  task automatic acc(input logic [4:0] a, input logic w,
                     input logic [31:0] d);
    @(posedge clk_sys);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e)
    begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    acc(a, 1'b0, 32'h0);
    chk(q, e);
  endtask
  // Send one word and wait until the station has framed it.
  task automatic tx(input logic [7:0] b);
    n0 = R.nGot;
    rtsCyc = 0;
    acc(OFS_TXDATA, 1'b1, {24'h0, b});
    while (R.nGot == n0) @(posedge clk_sys);
    while (serRts === 1'b1) @(posedge clk_sys);
  endtask
  task automatic summarize();
    if (fails == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // The whole run needs under ten thousand cycles; allow twice that.
  initial
  begin
    #200_000;
    fails++;
    summarize();
  end
  // Written control value, then the legalised value read back.
  logic [31:0] cfgTab [12] = '{32'h0EF, 32'h087, 32'h06F, 32'h06F,
    32'h887, 32'h087, 32'h587, 32'h187, 32'h1407, 32'h0407,
    32'h1A87, 32'h0A87};
  initial
  begin
    repeat (20) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rd(OFS_CTRL, 32'h7);
    rd(OFS_DELAY, 32'h0);
    rd(OFS_STATUS, 32'h3);
    rd(5'h14, 32'h0);
    for (int i = 0; i < 8; i++)
    begin
      acc(OFS_CTRL, 1'b1, 32'(i));
      rd(OFS_CTRL, 32'(i));
    end
    for (int i = 0; i < 12; i += 2)
    begin
      acc(OFS_CTRL, 1'b1, cfgTab[i]);
      rd(OFS_CTRL, cfgTab[i + 1]);
    end
    acc(OFS_DELAY, 1'b1, 32'h0302);
    acc(OFS_CTRL, 1'b1, 32'h7);
    tx(8'hA5);
    chk(R.got, 8'hA5);
    chk(rtsCyc, 0);
    acc(OFS_CTRL, 1'b1, 32'hF);
    tx(8'h55);
    chk(R.got, 8'hD5);
    acc(OFS_CTRL, 1'b1, 32'h407);
    tx(8'h3C);
    chk(R.got, 8'h3C);
    chk(32'(rtsCyc >= 1018 && rtsCyc <= 1023), 1);
    acc(OFS_CTRL, 1'b1, 32'h1807);
    repeat (10) @(posedge clk_sys);
    chk(serRts, 1'b1);
    acc(OFS_CTRL, 1'b1, 32'h7);
    R.send(8'h96);
    repeat (200) @(posedge clk_sys);
    rd(OFS_STATUS, 32'hB);
    rd(OFS_RXDATA, 32'h96);
    // Two unread words: the second overwrites and flags overrun.
    R.send(8'h5A);
    R.send(8'hC3);
    repeat (200) @(posedge clk_sys);
    rd(OFS_STATUS, 32'h1B);
    rd(OFS_RXDATA, 32'hC3);
    acc(OFS_STATUS, 1'b1, 32'h10);
    rd(OFS_STATUS, 32'h3);
    // A reset in mid-run must bring back the CTRL and STATUS defaults; RTS is checked high before it.
    acc(OFS_CTRL, 1'b1, 32'h1807);
    repeat (3) @(posedge clk_sys);
    chk(serRts, 1'b1);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rd(OFS_CTRL, 32'h7);
    rd(OFS_STATUS, 32'h3);
    summarize();
  end
endmodule
